/* pkg/cod_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cod_link_if;
  logic msg_valid;
  logic [2:0] msg_class;
  logic [3:0] msg_opcode;

  modport sender (output msg_valid, output msg_class, output msg_opcode);
  modport observer (input msg_valid, input msg_class, input msg_opcode);
endinterface : cod_link_if
`default_nettype wire

/* pkg/cod_pkg.sv */
`default_nettype none
package cod_pkg;

  // ---------------------------------------------------------------
  // message classes
  // ---------------------------------------------------------------
  localparam int COD_CLS_W = 3;
  localparam int COD_OPC_W = 4;
  localparam logic [2:0] COD_CLS_REQ = 3'h0;
  localparam logic [2:0] COD_CLS_SNOOP = 3'h1;
  localparam logic [2:0] COD_CLS_SHORT_RSP = 3'h2;
  localparam logic [2:0] COD_CLS_DATA_RSP = 3'h3;
  localparam logic [2:0] COD_CLS_WB = 3'h4;
  localparam logic [2:0] COD_CLS_NCB = 3'h5;

  // ---------------------------------------------------------------
  // message kinds; order matters where two share one code
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    unknown_kind,
    read_current, read_code_shared, read_data_es, read_data_migratory,
    read_invalidate_exclusive, read_for_ownership,
    conflict_response, forwarded_unchanged_resp, forwarded_now_invalid_resp,
    forwarded_now_shared_resp,
    forward_writeback_invalid_resp, forward_writeback_shared_resp,
    writeback_invalid_resp, writeback_shared_resp,
    snoop_snapshot, snoop_code_copy, snoop_data_copy, snoop_migratory,
    snoop_invalidate_own, snoop_invalidate_flush,
    fanout_snoop_snapshot, fanout_snoop_code_copy, fanout_snoop_data_copy,
    fanout_snoop_migratory, fanout_snoop_invalidate, fanout_snoop_invalidate_own,
    snoop_invalidate_writeback,
    writeback_to_invalid, writeback_to_shared, writeback_to_exclusive,
    partial_writeback_to_invalid, partial_writeback_to_exclusive,
    push_line_to_home, flush_writes_hint,
    combinable_io_write, combinable_io_partial_write,
    cod_kind_last
  } cod_kind_type;

  localparam int COD_NUM_KINDS = int'(cod_kind_last);

  // line state that results from the message
  typedef enum logic [3:0] {
    st_none, st_i, st_s, st_e, st_m, st_es, st_me, st_mes, st_unchanged
  } cod_state_type;

  typedef struct packed {
    logic ok;
    logic [2:0] cls;
    logic [3:0] opc;
  } cod_code_type;

  typedef struct packed {
    cod_state_type st;
    logic fwd;
    logic wb;
    logic fan;
  } cod_mean_type;

  // ---------------------------------------------------------------
  // code of each kind, always qualified by class
  // ---------------------------------------------------------------
  function automatic cod_code_type cod_encode(input cod_kind_type k);
    cod_code_type c;
    c = '{ok: 1'b1, cls: COD_CLS_REQ, opc: 4'h0};
    case (k)
      read_current: c.opc = 4'h0;
      read_code_shared: c.opc = 4'h1;
      read_data_es: c.opc = 4'h2;
      read_data_migratory: c.opc = 4'h3;
      read_invalidate_exclusive: c.opc = 4'hC;
      read_for_ownership: c.opc = 4'h4;
      conflict_response: c = '{1'b1, COD_CLS_SHORT_RSP, 4'hA};
      forwarded_unchanged_resp: c = '{1'b1, COD_CLS_SHORT_RSP, 4'h4};
      forwarded_now_invalid_resp: c = '{1'b1, COD_CLS_SHORT_RSP, 4'h5};
      forwarded_now_shared_resp: c = '{1'b1, COD_CLS_SHORT_RSP, 4'h6};
      forward_writeback_invalid_resp: c = '{1'b1, COD_CLS_DATA_RSP, 4'hA};
      forward_writeback_shared_resp: c = '{1'b1, COD_CLS_DATA_RSP, 4'hB};
      writeback_invalid_resp: c = '{1'b1, COD_CLS_DATA_RSP, 4'hC};
      writeback_shared_resp: c = '{1'b1, COD_CLS_DATA_RSP, 4'hD};
      snoop_snapshot: c = '{1'b1, COD_CLS_SNOOP, 4'h0};
      snoop_code_copy: c = '{1'b1, COD_CLS_SNOOP, 4'h1};
      snoop_data_copy: c = '{1'b1, COD_CLS_SNOOP, 4'h2};
      snoop_migratory: c = '{1'b1, COD_CLS_SNOOP, 4'h3};
      snoop_invalidate_own: c = '{1'b1, COD_CLS_SNOOP, 4'h4};
      snoop_invalidate_flush: c = '{1'b1, COD_CLS_SNOOP, 4'h5};
      fanout_snoop_snapshot: c = '{1'b1, COD_CLS_SNOOP, 4'h8};
      fanout_snoop_code_copy: c = '{1'b1, COD_CLS_SNOOP, 4'h9};
      fanout_snoop_data_copy: c = '{1'b1, COD_CLS_SNOOP, 4'hA};
      fanout_snoop_migratory: c = '{1'b1, COD_CLS_SNOOP, 4'hB};
      fanout_snoop_invalidate: c = '{1'b1, COD_CLS_SNOOP, 4'hD};
      fanout_snoop_invalidate_own: c = '{1'b1, COD_CLS_SNOOP, 4'hC};
      snoop_invalidate_writeback: c = '{1'b1, COD_CLS_SNOOP, 4'hC};
      writeback_to_invalid: c = '{1'b1, COD_CLS_WB, 4'h0};
      writeback_to_shared: c = '{1'b1, COD_CLS_WB, 4'h1};
      writeback_to_exclusive: c = '{1'b1, COD_CLS_WB, 4'h2};
      partial_writeback_to_invalid: c = '{1'b1, COD_CLS_WB, 4'h4};
      partial_writeback_to_exclusive: c = '{1'b1, COD_CLS_WB, 4'h6};
      push_line_to_home: c = '{1'b1, COD_CLS_WB, 4'h8};
      flush_writes_hint: c = '{1'b1, COD_CLS_WB, 4'hB};
      combinable_io_write: c = '{1'b1, COD_CLS_NCB, 4'h1};
      combinable_io_partial_write: c = '{1'b1, COD_CLS_NCB, 4'hD};
      default: c.ok = 1'b0;
    endcase
    return c;
  endfunction : cod_encode

endpackage : cod_pkg
`default_nettype wire

/* rtl/cod_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module cod_decoder (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // observed link
  cod_link_if.observer link,
  // decoded message
  output logic valid_o,
  output cod_pkg::cod_kind_type kind_o,
  output cod_pkg::cod_state_type state_o,
  output logic forwarded_o,
  output logic writes_memory_o,
  output logic fanout_o,
  output logic ambiguous_o,
  output logic unknown_o
);
  import cod_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    cod_kind_type kind;
    cod_mean_type mean;
    logic ambig;
    logic unknown;
  } cod_dec_type;

  typedef struct packed {
    cod_kind_type kind;
    logic ambig;
  } cod_hit_type;

  cod_dec_type s_q;
  cod_dec_type s_d;
  cod_hit_type hit;

  // ---------------------------------------------------------------
  // lookup by class and opcode
  // ---------------------------------------------------------------
  // searching the one encode table keeps both ends from drifting apart;
  // first kind in enum order wins a shared code
  function automatic cod_hit_type lookup(input logic [2:0] cls, input logic [3:0] opc);
    cod_hit_type h;
    cod_code_type c;
    h = '{kind: unknown_kind, ambig: 1'b0};
    for (int k = 1; k < COD_NUM_KINDS; k++) begin
      c = cod_encode(cod_kind_type'(k[5:0]));
      if (c.ok && c.cls == cls && c.opc == opc) begin
        if (h.kind == unknown_kind) begin
          h.kind = cod_kind_type'(k[5:0]);
        end else begin
          h.ambig = 1'b1;
        end
      end
    end
    return h;
  endfunction : lookup

  // ---------------------------------------------------------------
  // meaning record
  // ---------------------------------------------------------------
  function automatic cod_mean_type mk(input cod_state_type st, input logic fwd,
                                      input logic wb, input logic fan);
    mk.st = st;
    mk.fwd = fwd;
    mk.wb = wb;
    mk.fan = fan;
  endfunction : mk

  // ---------------------------------------------------------------
  // class screen
  // ---------------------------------------------------------------
  // class codes 6 and 7 are unused; screening them first keeps the
  // table search from matching on a class nobody sends
  function automatic logic class_known(input logic [2:0] cls);
    logic known;
    known = 1'b0;
    case (cls)
      COD_CLS_REQ: known = 1'b1;
      COD_CLS_SNOOP: known = 1'b1;
      COD_CLS_SHORT_RSP: known = 1'b1;
      COD_CLS_DATA_RSP: known = 1'b1;
      COD_CLS_WB: known = 1'b1;
      COD_CLS_NCB: known = 1'b1;
      default: known = 1'b0;
    endcase
    return known;
  endfunction : class_known

  // ---------------------------------------------------------------
  // cache-state meaning of each kind
  // ---------------------------------------------------------------
  // state is the requester's outcome for requests and snoops,
  // the responder's or writer's for responses and writebacks
  function automatic cod_mean_type meaning(input cod_kind_type k);
    cod_mean_type m;
    m = mk(st_none, 1'b0, 1'b0, 1'b0);
    case (k)
      read_current: m = mk(st_i, 1'b0, 1'b0, 1'b0);
      read_code_shared: m = mk(st_s, 1'b0, 1'b0, 1'b0);
      read_data_es: m = mk(st_es, 1'b0, 1'b0, 1'b0);
      read_data_migratory: m = mk(st_mes, 1'b0, 1'b0, 1'b0);
      read_invalidate_exclusive: m = mk(st_e, 1'b0, 1'b1, 1'b0);
      read_for_ownership: m = mk(st_me, 1'b0, 1'b0, 1'b0);
      conflict_response: m = mk(st_none, 1'b0, 1'b0, 1'b0);
      forwarded_unchanged_resp: m = mk(st_unchanged, 1'b1, 1'b0, 1'b0);
      forwarded_now_invalid_resp: m = mk(st_i, 1'b1, 1'b0, 1'b0);
      forwarded_now_shared_resp: m = mk(st_s, 1'b1, 1'b0, 1'b0);
      forward_writeback_invalid_resp: m = mk(st_i, 1'b1, 1'b1, 1'b0);
      forward_writeback_shared_resp: m = mk(st_s, 1'b1, 1'b1, 1'b0);
      writeback_invalid_resp: m = mk(st_i, 1'b0, 1'b1, 1'b0);
      writeback_shared_resp: m = mk(st_s, 1'b0, 1'b1, 1'b0);
      snoop_snapshot: m = mk(st_i, 1'b0, 1'b0, 1'b0);
      snoop_code_copy: m = mk(st_s, 1'b0, 1'b0, 1'b0);
      snoop_data_copy: m = mk(st_es, 1'b0, 1'b0, 1'b0);
      snoop_migratory: m = mk(st_mes, 1'b0, 1'b0, 1'b0);
      snoop_invalidate_own: m = mk(st_me, 1'b0, 1'b0, 1'b0);
      snoop_invalidate_flush: m = mk(st_i, 1'b0, 1'b1, 1'b0);
      fanout_snoop_snapshot: m = mk(st_i, 1'b0, 1'b0, 1'b1);
      fanout_snoop_code_copy: m = mk(st_s, 1'b0, 1'b0, 1'b1);
      fanout_snoop_data_copy: m = mk(st_es, 1'b0, 1'b0, 1'b1);
      fanout_snoop_migratory: m = mk(st_mes, 1'b0, 1'b0, 1'b1);
      fanout_snoop_invalidate: m = mk(st_i, 1'b0, 1'b1, 1'b1);
      fanout_snoop_invalidate_own: m = mk(st_me, 1'b0, 1'b0, 1'b1);
      snoop_invalidate_writeback: m = mk(st_i, 1'b0, 1'b1, 1'b0);
      writeback_to_invalid: m = mk(st_i, 1'b0, 1'b1, 1'b0);
      writeback_to_shared: m = mk(st_s, 1'b0, 1'b1, 1'b0);
      writeback_to_exclusive: m = mk(st_e, 1'b0, 1'b1, 1'b0);
      partial_writeback_to_invalid: m = mk(st_i, 1'b0, 1'b1, 1'b0);
      partial_writeback_to_exclusive: m = mk(st_e, 1'b0, 1'b1, 1'b0);
      // home may keep it in a local cache instead of memory
      push_line_to_home: m = mk(st_i, 1'b0, 1'b1, 1'b0);
      // hint only, no data and no state change
      flush_writes_hint: m = mk(st_none, 1'b0, 1'b0, 1'b0);
      combinable_io_write: m = mk(st_none, 1'b0, 1'b1, 1'b0);
      combinable_io_partial_write: m = mk(st_none, 1'b0, 1'b1, 1'b0);
      default: m = mk(st_none, 1'b0, 1'b0, 1'b0);
    endcase
    return m;
  endfunction : meaning

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    hit = class_known(link.msg_class) ? lookup(link.msg_class, link.msg_opcode)
                                      : cod_hit_type'{kind: unknown_kind, ambig: 1'b0};
    s_d = s_q;
    s_d.valid = link.msg_valid;
    // fields hold between messages so a slow reader still sees the last one
    if (link.msg_valid) begin
      s_d.kind = hit.kind;
      s_d.mean = meaning(hit.kind);
      s_d.ambig = hit.ambig;
      s_d.unknown = (hit.kind == unknown_kind);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '{
        valid: 1'b0,
        kind: unknown_kind,
        mean: '{st: st_none, fwd: 1'b0, wb: 1'b0, fan: 1'b0},
        ambig: 1'b0,
        unknown: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign valid_o = s_q.valid;
  assign kind_o = s_q.kind;
  assign state_o = s_q.mean.st;
  assign forwarded_o = s_q.mean.fwd;
  assign writes_memory_o = s_q.mean.wb;
  assign fanout_o = s_q.mean.fan;
  assign ambiguous_o = s_q.ambig;
  assign unknown_o = s_q.unknown;

endmodule : cod_decoder
`default_nettype wire

/* rtl/cod_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// agent end: puts one named message on the link per request of a kind that has a code
// ---------------------------------------------------------------
module cod_encoder (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // user side
  input wire logic send_i,
  input wire cod_pkg::cod_kind_type kind_i,
  output logic reject_o,
  // link side
  cod_link_if.sender link
);
  import cod_pkg::*;

  typedef struct packed {
    logic valid;
    logic [2:0] cls;
    logic [3:0] opc;
    logic reject;
  } cod_enc_type;

  cod_enc_type s_q;
  cod_enc_type s_d;
  cod_code_type code;

  always_comb begin
    code = cod_encode(kind_i);
    s_d = s_q;
    s_d.valid = send_i && code.ok;
    // kinds without a code are refused, link keeps its last fields
    s_d.reject = send_i && !code.ok;
    if (send_i && code.ok) begin
      s_d.cls = code.cls;
      s_d.opc = code.opc;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.msg_valid = s_q.valid;
  assign link.msg_class = s_q.cls;
  assign link.msg_opcode = s_q.opc;
  assign reject_o = s_q.reject;

endmodule : cod_encoder
`default_nettype wire

/* verif/cod_link_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cod_link_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // agent user side
  input wire logic send_i,
  input wire cod_pkg::cod_kind_type kind_i,
  input wire logic reject_o,
  // link
  input wire logic msg_valid,
  input wire logic [2:0] msg_class,
  input wire logic [3:0] msg_opcode,
  // decoded message
  input wire logic valid_o,
  input wire cod_pkg::cod_kind_type kind_o,
  input wire logic forwarded_o,
  input wire logic writes_memory_o,
  input wire logic fanout_o,
  input wire logic ambiguous_o
);
  import cod_pkg::*;
  // ---------------------------------------------------------------
  // link and decode relations
  // ---------------------------------------------------------------
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  valid_follow_a: assert property (msg_valid |=> valid_o)
    else $error("decoded pulse missing after a link message");
  valid_quiet_a: assert property (!msg_valid |=> !valid_o)
    else $error("decoded pulse without a link message");
  kind_hold_a: assert property (!msg_valid |=> $stable(kind_o))
    else $error("decoded kind changed with no message");
  code_read_a: assert property (msg_valid && msg_class == COD_CLS_REQ && msg_opcode == 4'h1
    |=> kind_o == read_code_shared) else $error("request 1 not decoded as code read");
  class_qual_a: assert property (msg_valid && msg_class == COD_CLS_SNOOP && msg_opcode == 4'h4
    |=> kind_o == snoop_invalidate_own) else $error("snoop 4 decoded without its class");
  snoop_ambig_a: assert property (msg_valid && msg_class == COD_CLS_SNOOP && msg_opcode == 4'hC
    |=> ambiguous_o && fanout_o) else $error("snoop C not flagged as shared code");
  fanout_set_a: assert property (msg_valid && msg_class == COD_CLS_SNOOP && msg_opcode[3]
    |=> fanout_o) else $error("upper snoop code not flagged fanout");
  fanout_clr_a: assert property (msg_valid && msg_class == COD_CLS_SNOOP && !msg_opcode[3]
    |=> !fanout_o) else $error("lower snoop code flagged fanout");
  fwd_wb_a: assert property (msg_valid && msg_class == COD_CLS_DATA_RSP && msg_opcode[3:1] == 3'h5
    |=> forwarded_o && writes_memory_o) else $error("forward plus writeback flags wrong");
  wb_only_a: assert property (msg_valid && msg_class == COD_CLS_DATA_RSP && msg_opcode[3:1] == 3'h6
    |=> !forwarded_o && writes_memory_o) else $error("writeback only flags wrong");
  send_code_a: assert property (send_i && kind_i == read_data_es
    |=> msg_valid && msg_class == COD_CLS_REQ && msg_opcode == 4'h2) else $error("data read code wrong");
  send_reject_a: assert property (send_i && kind_i == unknown_kind |=> reject_o && !msg_valid)
    else $error("kind without code not refused");
  end_to_end_a: assert property (send_i && kind_i == writeback_to_shared
    |=> ##1 valid_o && kind_o == writeback_to_shared) else $error("end to end writeback wrong");
endmodule : cod_link_asserts
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cod_pkg::*;
  typedef struct packed {
    cod_kind_type kind;
    logic fan;
    logic amb;
    logic chk;
    cod_state_type st;
  } cod_note_type;
  logic clk_i, nrst_i, send_i, reject_o, valid_o, forwarded_o, writes_memory_o;
  logic fanout_o, ambiguous_o, unknown_o;
  cod_kind_type kind_i, kind_o;
  cod_state_type state_o;
  int err_total, checks_done;
  logic [7:0] code_tab [0:36];
  logic [7:0] wire_q [$];
  cod_note_type dec_q [$];
  logic [7:0] w_exp;
  cod_note_type n_got;

  cod_link_if u_cod_link_if ();
  cod_encoder u_cod_encoder (.clk_i(clk_i), .nrst_i(nrst_i), .send_i(send_i), .kind_i(kind_i),
    .reject_o(reject_o), .link(u_cod_link_if.sender));
  cod_decoder u_cod_decoder (.clk_i(clk_i), .nrst_i(nrst_i), .link(u_cod_link_if.observer),
    .valid_o(valid_o), .kind_o(kind_o), .state_o(state_o), .forwarded_o(forwarded_o),
    .writes_memory_o(writes_memory_o), .fanout_o(fanout_o), .ambiguous_o(ambiguous_o),
    .unknown_o(unknown_o));
  cod_link_asserts u_cod_link_asserts (.clk_i(clk_i), .nrst_i(nrst_i), .send_i(send_i),
    .kind_i(kind_i), .reject_o(reject_o), .msg_valid(u_cod_link_if.msg_valid),
    .msg_class(u_cod_link_if.msg_class), .msg_opcode(u_cod_link_if.msg_opcode),
    .valid_o(valid_o), .kind_o(kind_o), .forwarded_o(forwarded_o),
    .writes_memory_o(writes_memory_o), .fanout_o(fanout_o), .ambiguous_o(ambiguous_o));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // compares and closing
  // ---------------------------------------------------------------
  task automatic chk_bits(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bits

  task automatic chk_kind(input cod_kind_type g, input cod_kind_type e);
    chk_bits({2'h0, g}, {2'h0, e});
  endtask : chk_kind

  task automatic chk_state(input cod_state_type g, input cod_state_type e);
    chk_bits({4'h0, g}, {4'h0, e});
  endtask : chk_state

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // only states the line descriptions pin down; others are left unchecked
  function automatic logic [4:0] exp_state(input cod_kind_type k);
    case (k)
      read_code_shared, forwarded_now_shared_resp, forward_writeback_shared_resp,
      writeback_shared_resp, snoop_code_copy, writeback_to_shared: return {1'b1, st_s};
      read_data_es, snoop_data_copy: return {1'b1, st_es};
      read_invalidate_exclusive, writeback_to_exclusive,
      partial_writeback_to_exclusive: return {1'b1, st_e};
      read_for_ownership, snoop_invalidate_own: return {1'b1, st_me};
      snoop_migratory: return {1'b1, st_mes};
      forwarded_unchanged_resp: return {1'b1, st_unchanged};
      read_current, forwarded_now_invalid_resp, forward_writeback_invalid_resp,
      writeback_invalid_resp, writeback_to_invalid, partial_writeback_to_invalid,
      push_line_to_home: return {1'b1, st_i};
      default: return 5'h00;
    endcase
  endfunction : exp_state

  // ---------------------------------------------------------------
  // driver notes what each send must produce
  // ---------------------------------------------------------------
  task automatic send(input cod_kind_type k);
    cod_note_type n;
    logic [7:0] c;
    @(posedge clk_i);
    #2;
    send_i = 1'b1;
    kind_i = k;
    c = (int'(k) < COD_NUM_KINDS) ? code_tab[int'(k)] : 8'hFF;
    wire_q.push_back(c);
    if (c != 8'hFF) begin
      n.kind = (k == snoop_invalidate_writeback) ? fanout_snoop_invalidate_own : k;
      n.fan = (c[6:4] == 3'h1) && c[3];
      n.amb = (c == 8'h1C);
      {n.chk, n.st} = exp_state(k);
      dec_q.push_back(n);
    end
  endtask : send

  task automatic idle();
    @(posedge clk_i);
    #2;
    send_i = 1'b0;
  endtask : idle

  always @(negedge clk_i) begin
    if (nrst_i && (u_cod_link_if.msg_valid || reject_o)) begin
      w_exp = (wire_q.size() > 0) ? wire_q.pop_front() : 8'hEE;
      chk_bits(reject_o ? 8'hFF : {1'b0, u_cod_link_if.msg_class, u_cod_link_if.msg_opcode},
        w_exp);
    end
    if (nrst_i && valid_o) begin
      n_got = (dec_q.size() > 0) ? dec_q.pop_front() : '0;
      chk_kind(kind_o, n_got.kind);
      chk_bits({5'h0, fanout_o, ambiguous_o, unknown_o}, {5'h0, n_got.fan, n_got.amb, 1'b0});
      if (n_got.chk) chk_state(state_o, n_got.st);
    end
  end

  initial begin
    #100000;
    err_total++;
    end_of_test();
  end

  initial begin
    send_i = 1'b0;
    kind_i = unknown_kind;
    nrst_i = 1'b0;
    err_total = 0;
    checks_done = 0;
    code_tab = '{8'hFF, 8'h00, 8'h01, 8'h02, 8'h03, 8'h0C, 8'h04,
      8'h2A, 8'h24, 8'h25, 8'h26,
      8'h3A, 8'h3B, 8'h3C, 8'h3D,
      8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
      8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1C, 8'h1C,
      8'h40, 8'h41, 8'h42, 8'h44, 8'h46, 8'h48, 8'h4B,
      8'h51, 8'h5D};
    void'($urandom(49090));
    repeat (5) @(posedge clk_i);
    #2;
    nrst_i = 1'b1;
    // every kind back to back, plus two values with no code
    for (int k = 0; k <= COD_NUM_KINDS; k++) send(cod_kind_type'(k));
    repeat (4) idle();
    $display("test sweep done");
    repeat (300) begin
      if ($urandom % 4 == 0) idle();
      else send(cod_kind_type'($urandom % 40));
    end
    repeat (4) idle();
    $display("test random done");
    // reset lands while a message is in flight
    send(conflict_response);
    @(posedge clk_i);
    #2;
    nrst_i = 1'b0;
    send_i = 1'b0;
    @(negedge clk_i);
    chk_kind(kind_o, unknown_kind);
    chk_state(state_o, st_none);
    chk_bits({7'h0, valid_o | u_cod_link_if.msg_valid}, 8'h00);
    wire_q.delete();
    dec_q.delete();
    @(posedge clk_i);
    #2;
    nrst_i = 1'b1;
    send(read_data_migratory);
    repeat (4) idle();
    chk_bits(8'(wire_q.size() + dec_q.size()), 8'h00);
    $display("test reset done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
